// ==== isl_pkg.sv ====
// constants, field layout and state type of the two-wire slave transfer engine
package isl_pkg;

  // ==========================================================
  // widths
  localparam int ISL_ADDR_W = 7;
  localparam int ISL_BYTE_W = 8;
  localparam int ISL_HOLD_W = 8;
  localparam int ISL_CNT_W = 4;

  // ==========================================================
  // values
  localparam logic [7:0] ISL_GEN_CALL_ADDR = 8'h00;
  localparam logic [7:0] ISL_STATUS_RELEASE = 8'h00;
  localparam logic [7:0] ISL_STATUS_CLEAR_ALL = 8'hff;
  localparam logic [3:0] ISL_LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ISL_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ISL_ACK_BIT = 4'h9;
  localparam logic [7:0] ISL_STATUS_RESET = 8'h00;
  localparam logic [7:0] ISL_BYTE_RESET = 8'h00;

  // ==========================================================
  // status register field positions
  localparam int ISL_ST_SEL = 0;
  localparam int ISL_ST_TEND = 1;
  localparam int ISL_ST_STOP = 2;
  localparam int ISL_ST_RXACK = 3;
  localparam int ISL_ST_TX = 4;
  localparam int ISL_ST_BUSY = 5;

  // ==========================================================
  // engine states
  typedef enum logic [6:0] {
    ISL_IDLE = 7'b000_0001,
    ISL_ADDR = 7'b000_0010,
    ISL_ADDR_ACK = 7'b000_0100,
    ISL_HOLD = 7'b000_1000,
    ISL_DATA = 7'b001_0000,
    ISL_DATA_ACK = 7'b010_0000,
    ISL_WAIT = 7'b100_0000
  } isl_state_e;

endpackage

// ==== isl_link_if.sv ====
// signals between the pin-facing engine and the scl-clocked bit sampler
interface isl_link_if;
  logic scl;
  logic sda;
  logic rst_n;
  logic [7:0] shift;

  modport engine (output scl, output sda, output rst_n, input shift);
  modport sampler (input scl, input sda, input rst_n, output shift);
endinterface

// ==== isl_link_sampler.sv ====
// shift register clocked by the bus clock, samples sda at each scl rise
module isl_link_sampler (
  // link side
  isl_link_if.sampler lnk
);

  // ==========================================================
  // sampling on the bus clock itself
  always_ff @(posedge lnk.scl or negedge lnk.rst_n) begin
    if (!lnk.rst_n) begin
      lnk.shift <= 8'h00;
    end else begin
      lnk.shift <= {lnk.shift[6:0], lnk.sda};
    end
  end

endmodule // isl_link_sampler

// ==== isl_slave_top.sv ====
// two-wire slave transfer engine: address match, stretching, data bytes
module isl_slave_top
  import isl_pkg::*;
#(
  parameter int HOLD_W = ISL_HOLD_W
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // bus clock pin
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  // bus data pin
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // control
  input wire logic controller_enable_bit_i,
  input wire logic irq_enable_bit_i,
  input wire logic ack_enable_i,
  input wire logic [HOLD_W-1:0] sda_hold_count_i,
  // own addresses
  input wire logic [ISL_ADDR_W-1:0] own_address_field1_i,
  input wire logic [ISL_ADDR_W-1:0] own_address_field2_i,
  input wire logic general_call_enable1_i,
  input wire logic general_call_enable2_i,
  // data register
  input wire logic data_reg_we_i,
  input wire logic [ISL_BYTE_W-1:0] data_reg_wdata_i,
  output logic [ISL_BYTE_W-1:0] data_reg_o,
  // status register
  input wire logic status_we_i,
  input wire logic [7:0] status_wdata_i,
  output logic [7:0] status_reg_o,
  output logic irq_o
);

  // ==========================================================
  // reset release
  logic rst_m;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // ==========================================================
  // scl-domain sampler
  isl_link_if lnk ();

  assign lnk.scl = scl_i;
  assign lnk.sda = sda_i;
  assign lnk.rst_n = rst_n;

  isl_link_sampler u_sampler (
    .lnk(lnk)
  );

  // ==========================================================
  // pin synchronisers
  logic scl_m;
  logic scl_s;
  logic scl_d;
  logic sda_m;
  logic sda_s;
  logic sda_d;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // ==========================================================
  // bus events
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire scl_high = scl_s & scl_d;
  wire start_det = scl_high & sda_d & ~sda_s;
  wire stop_det = scl_high & ~sda_d & sda_s;
  wire active = controller_enable_bit_i & irq_enable_bit_i;

  // ==========================================================
  // state
  isl_state_e state;
  isl_state_e next_state;
  logic [ISL_CNT_W-1:0] bit_cnt;
  logic [ISL_CNT_W-1:0] next_bit_cnt;
  logic [ISL_BYTE_W-1:0] addr_byte;
  logic [ISL_BYTE_W-1:0] tx_byte;
  logic [ISL_BYTE_W-1:0] tx_shift;
  logic [ISL_BYTE_W-1:0] next_tx_shift;
  logic go_wait;
  logic next_go_wait;
  logic [HOLD_W-1:0] hold_cnt;
  logic pend_valid;
  logic pend_val;

  // ==========================================================
  // address decode
  wire [ISL_ADDR_W-1:0] addr_field = addr_byte[7:1];
  wire own_hit = (addr_field == own_address_field1_i)
    | (addr_field == own_address_field2_i);
  wire gc_hit = (general_call_enable1_i | general_call_enable2_i)
    & (addr_byte == ISL_GEN_CALL_ADDR);
  wire addr_hit = own_hit | gc_hit;
  wire addr_ack = addr_hit & ack_enable_i;
  wire is_tx = status_reg_o[ISL_ST_TX];

  // ==========================================================
  // software writes to status
  wire wr_release = status_we_i & (status_wdata_i == ISL_STATUS_RELEASE);
  wire wr_clear_all = status_we_i
    & (status_wdata_i == ISL_STATUS_CLEAR_ALL);
  wire hold_zero = (sda_hold_count_i == '0);

  // ==========================================================
  // next state
  logic set_sel;
  logic set_tend;
  logic set_stop;
  logic cap_addr;
  logic cap_data;
  logic next_scl_low;
  logic direct_sda;
  logic direct_val;
  logic req_sda;
  logic req_val;
  logic next_rx_ack;
  logic next_tx_mode;

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_tx_shift = tx_shift;
    next_go_wait = go_wait;
    next_scl_low = scl_oe_o;
    next_rx_ack = status_reg_o[ISL_ST_RXACK];
    next_tx_mode = status_reg_o[ISL_ST_TX];
    set_sel = 1'b0;
    set_tend = 1'b0;
    set_stop = 1'b0;
    cap_addr = 1'b0;
    cap_data = 1'b0;
    direct_sda = 1'b0;
    direct_val = 1'b0;
    req_sda = 1'b0;
    req_val = 1'b0;
    if (!active) begin
      next_state = ISL_IDLE;
      next_scl_low = 1'b0;
      direct_sda = 1'b1;
    end else if (wr_clear_all) begin
      next_state = ISL_IDLE;
      next_scl_low = 1'b0;
      direct_sda = 1'b1;
      next_rx_ack = 1'b0;
      next_tx_mode = 1'b0;
    end else if (stop_det && state != ISL_IDLE) begin
      set_stop = 1'b1;
      next_state = ISL_IDLE;
      next_scl_low = 1'b0;
      direct_sda = 1'b1;
    end else if (start_det) begin
      next_state = ISL_ADDR;
      next_bit_cnt = '0;
      next_scl_low = 1'b0;
      direct_sda = 1'b1;
    end else begin
      case (state)
        ISL_IDLE: begin
          next_bit_cnt = '0;
        end
        ISL_ADDR: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
            cap_addr = (bit_cnt == ISL_LAST_DATA_BIT);
          end
          if (scl_fall && bit_cnt == ISL_BITS_PER_BYTE) begin
            if (addr_ack) begin
              next_state = ISL_ADDR_ACK;
              req_sda = 1'b1;
              req_val = 1'b1;
              next_tx_mode = addr_byte[0];
            end else begin
              next_state = ISL_IDLE;
            end
          end
        end
        ISL_ADDR_ACK: begin
          if (scl_rise) begin
            next_bit_cnt = ISL_ACK_BIT;
          end
          if (scl_fall && bit_cnt == ISL_ACK_BIT) begin
            set_sel = 1'b1;
            next_scl_low = 1'b1;
            direct_sda = 1'b1;
            next_go_wait = 1'b0;
            next_state = ISL_HOLD;
          end
        end
        ISL_HOLD: begin
          if (wr_release) begin
            next_scl_low = 1'b0;
            next_bit_cnt = '0;
            direct_sda = 1'b1;
            if (go_wait) begin
              next_state = ISL_WAIT;
            end else begin
              next_state = ISL_DATA;
              if (is_tx) begin
                next_tx_shift = tx_byte;
                direct_val = ~tx_byte[7];
              end
            end
          end
        end
        ISL_DATA: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
            cap_data = ~is_tx & (bit_cnt == ISL_LAST_DATA_BIT);
          end
          if (scl_fall && bit_cnt < ISL_BITS_PER_BYTE && bit_cnt != '0) begin
            if (is_tx) begin
              next_tx_shift = {tx_shift[6:0], 1'b0};
              req_sda = 1'b1;
              req_val = ~tx_shift[6];
            end
          end
          if (scl_fall && bit_cnt == ISL_BITS_PER_BYTE) begin
            next_state = ISL_DATA_ACK;
            req_sda = 1'b1;
            req_val = ~is_tx & ack_enable_i;
            next_go_wait = ~is_tx & ~ack_enable_i;
          end
        end
        ISL_DATA_ACK: begin
          if (scl_rise) begin
            next_bit_cnt = ISL_ACK_BIT;
            next_rx_ack = ~sda_s;
            if (is_tx) begin
              next_go_wait = sda_s;
            end
          end
          if (scl_fall && bit_cnt == ISL_ACK_BIT) begin
            set_tend = 1'b1;
            next_scl_low = 1'b1;
            direct_sda = 1'b1;
            next_state = ISL_HOLD;
          end
        end
        ISL_WAIT: begin
          next_bit_cnt = '0;
        end
        default: begin
          next_state = ISL_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // engine registers
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ISL_IDLE;
      bit_cnt <= '0;
      tx_shift <= ISL_BYTE_RESET;
      go_wait <= 1'b0;
      scl_oe_o <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      tx_shift <= next_tx_shift;
      go_wait <= next_go_wait;
      scl_oe_o <= next_scl_low;
    end
  end

  // ==========================================================
  // byte capture from the scl-domain shift register
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_byte <= ISL_BYTE_RESET;
      data_reg_o <= ISL_BYTE_RESET;
      tx_byte <= ISL_BYTE_RESET;
    end else begin
      if (cap_addr) begin
        addr_byte <= lnk.shift;
      end
      if (cap_data) begin
        data_reg_o <= lnk.shift;
      end
      if (data_reg_we_i) begin
        tx_byte <= data_reg_wdata_i;
      end
    end
  end

  // ==========================================================
  // sda drive with programmed hold
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe_o <= 1'b0;
      pend_valid <= 1'b0;
      pend_val <= 1'b0;
      hold_cnt <= '0;
    end else if (direct_sda) begin
      sda_oe_o <= direct_val;
      pend_valid <= 1'b0;
    end else if (req_sda && hold_zero) begin
      sda_oe_o <= req_val;
      pend_valid <= 1'b0;
    end else if (req_sda) begin
      pend_valid <= 1'b1;
      pend_val <= req_val;
      hold_cnt <= sda_hold_count_i;
    end else if (pend_valid) begin
      if (hold_cnt == {{(HOLD_W-1){1'b0}}, 1'b1}) begin
        sda_oe_o <= pend_val;
        pend_valid <= 1'b0;
      end
      hold_cnt <= hold_cnt - {{(HOLD_W-1){1'b0}}, 1'b1};
    end
  end

  // ==========================================================
  // status register, a set beats a clear in the same cycle
  wire clr_src = wr_release | wr_clear_all;
  wire busy = (next_state != ISL_IDLE);

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      status_reg_o <= ISL_STATUS_RESET;
      irq_o <= 1'b0;
    end else begin
      status_reg_o[ISL_ST_SEL] <= set_sel
        | (status_reg_o[ISL_ST_SEL] & ~clr_src);
      status_reg_o[ISL_ST_TEND] <= set_tend
        | (status_reg_o[ISL_ST_TEND] & ~clr_src);
      status_reg_o[ISL_ST_STOP] <= set_stop
        | (status_reg_o[ISL_ST_STOP] & ~wr_clear_all);
      status_reg_o[ISL_ST_RXACK] <= next_rx_ack;
      status_reg_o[ISL_ST_TX] <= next_tx_mode;
      status_reg_o[ISL_ST_BUSY] <= busy;
      status_reg_o[7:6] <= 2'b00;
      irq_o <= irq_enable_bit_i & (status_reg_o[ISL_ST_SEL]
        | status_reg_o[ISL_ST_TEND] | status_reg_o[ISL_ST_STOP]);
    end
  end

  // ==========================================================
  // open-drain levels, always low when enabled
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

endmodule // isl_slave_top

// ==== isl_slave_props.sv ====
// assertion checker watching the ports of the two-wire slave engine
module isl_slave_props
  import isl_pkg::*;
#(
  parameter int HOLD_W = ISL_HOLD_W
) (
  // clock, reset and pins
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // control and addresses
  input wire logic controller_enable_bit_i,
  input wire logic irq_enable_bit_i,
  input wire logic ack_enable_i,
  input wire logic [HOLD_W-1:0] sda_hold_count_i,
  input wire logic [ISL_ADDR_W-1:0] own_address_field1_i,
  input wire logic [ISL_ADDR_W-1:0] own_address_field2_i,
  input wire logic general_call_enable1_i,
  input wire logic general_call_enable2_i,
  // data and status
  input wire logic data_reg_we_i,
  input wire logic [ISL_BYTE_W-1:0] data_reg_wdata_i,
  input wire logic [ISL_BYTE_W-1:0] data_reg_o,
  input wire logic status_we_i,
  input wire logic [7:0] status_wdata_i,
  input wire logic [7:0] status_reg_o,
  input wire logic irq_o
);
  // ==========================================================
  // properties
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  wire en = controller_enable_bit_i && irq_enable_bit_i;
  wire clr0 = status_we_i && status_wdata_i == 8'h00;
  wire clr1 = status_we_i && status_wdata_i == 8'hff;
  property p_irq;
    irq_o == $past(irq_enable_bit_i && |status_reg_o[2:0]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");
  property p_sel; $rose(status_reg_o[0]) |-> scl_oe_o; endproperty
  a_sel: assert property (p_sel) else $error("select without stretch");
  property p_tend; $rose(status_reg_o[1]) |-> scl_oe_o; endproperty
  a_tend: assert property (p_tend) else $error("end without stretch");
  property p_rel;
    clr0 && scl_oe_o |=> !scl_oe_o && status_reg_o[1:0] == 2'b00;
  endproperty
  a_rel: assert property (p_rel) else $error("clear did not release");
  property p_keep; scl_oe_o && !status_we_i && en |=> scl_oe_o; endproperty
  a_keep: assert property (p_keep) else $error("stretch dropped");
  property p_all;
    clr1 |=> status_reg_o[5:0] == 6'h00 && !scl_oe_o && !sda_oe_o;
  endproperty
  a_all: assert property (p_all) else $error("clear all failed");
  property p_off;
    !en |=> !$rose(status_reg_o[0]) && !$rose(status_reg_o[1]);
  endproperty
  a_off: assert property (p_off) else $error("flag while disabled");
  property p_ack; $rose(status_reg_o[0]) |-> $past(ack_enable_i); endproperty
  a_ack: assert property (p_ack) else $error("select without ack enable");
  property p_pins; !scl_o && !sda_o; endproperty
  a_pins: assert property (p_pins) else $error("pin driven high");
  c_sel: cover property ($rose(status_reg_o[0]));
  c_tend: cover property ($rose(status_reg_o[1]));
  c_stop: cover property ($rose(status_reg_o[2]));
endmodule // isl_slave_props

// ==== isl_master_model.sv ====
// behavioural two-wire bus master for the slave engine's pins
module isl_master_model (
  // wire levels
  input wire logic scl_i,
  input wire logic sda_i,
  // open-drain pulls, high pulls the wire low
  output logic scl_lo_o,
  output logic sda_lo_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime T_HI = 25.0;
  localparam realtime T_LO = 100.0;
  initial begin
    scl_lo_o = 1'b0;
    sda_lo_o = 1'b0;
  end
  // one clock pulse, waits out any stretching first
  task automatic pulse(output logic b);
    scl_lo_o = 1'b0;
    wait (scl_i);
    #(T_HI / 2) b = sda_i;
    #(T_HI / 2) scl_lo_o = 1'b1;
    #(T_LO / 2);
  endtask
  task automatic bitx(input logic v, output logic b);
    sda_lo_o = !v;
    #(T_LO / 2);
    pulse(b);
  endtask
  // eight bits msb first then the ninth; r holds the wire seen
  task automatic xfer(input logic [7:0] d, input logic ack,
    output logic [8:0] r);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], b);
      r = {r[7:0], b};
    end
    bitx(ack, b);
    r = {r[7:0], b};
  endtask
  task automatic start;
    sda_lo_o = 1'b0;
    #(T_LO / 2);
    scl_lo_o = 1'b0;
    wait (scl_i);
    #T_LO sda_lo_o = 1'b1;
    #T_LO scl_lo_o = 1'b1;
    #(T_LO / 2);
  endtask
  task automatic stop;
    sda_lo_o = 1'b1;
    #(T_LO / 2);
    scl_lo_o = 1'b0;
    wait (scl_i);
    #T_LO sda_lo_o = 1'b0;
    #T_LO;
  endtask
endmodule // isl_master_model

// ==== isl_slave_top_bench.sv ====
// self-checking bench for the two-wire slave transfer engine
module isl_slave_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // signals
  logic clk_sys_i = 0, reset_n_i = 0;
  logic controller_enable_bit_i = 1, irq_enable_bit_i = 1, ack_enable_i = 1;
  logic [7:0] sda_hold_count_i = 8'h00;
  logic [6:0] own_address_field1_i = 7'h2c, own_address_field2_i = 7'h51;
  logic general_call_enable1_i = 0, general_call_enable2_i = 0;
  logic data_reg_we_i = 0, status_we_i = 0, m_scl, m_sda, meas = 0, v;
  logic [7:0] data_reg_wdata_i = 8'h00, status_wdata_i = 8'h00;
  wire scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o;
  wire [7:0] data_reg_o, status_reg_o;
  wire scl_i = !(scl_oe_o || m_scl);
  wire sda_i = !(sda_oe_o || m_sda);
  logic [8:0] r;
  int fail_count = 0, checks = 0, cyc = 0, lat = 0, n;
  isl_slave_top uut (.*);
  isl_master_model mst (.scl_i(scl_i), .sda_i(sda_i), .scl_lo_o(m_scl),
    .sda_lo_o(m_sda));
  initial begin
    forever #10 clk_sys_i = !clk_sys_i;
  end
  // ==========================================================
  // tasks
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask
  task automatic chk(input string nm, input logic [8:0] got, exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // st high writes status, low loads the transmit byte
  task automatic put(input logic st, input logic [7:0] d);
    @(posedge clk_sys_i);
    status_we_i <= st;
    data_reg_we_i <= !st;
    status_wdata_i <= d;
    data_reg_wdata_i <= d;
    @(posedge clk_sys_i);
    status_we_i <= 1'b0;
    data_reg_we_i <= 1'b0;
    tick(2);
  endtask
  task automatic stat(input logic [7:0] e);
    tick(6);
    chk("status", {1'b0, status_reg_o & 8'h37}, {1'b0, e});
    chk("irq", {8'h00, irq_o}, {8'h00, |e[2:0]});
  endtask
  task automatic held(input logic [7:0] e);
    stat(e);
    chk("stretch", {8'h00, scl_oe_o}, 9'h001);
  endtask
  task automatic addr(input logic [7:0] a);
    mst.start();
    mst.xfer(a, 1'b1, r);
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // system clocks from a bus clock fall to a data line change
  always @(negedge scl_i) if (meas) begin
    n = 0;
    v = sda_oe_o;
    while (sda_oe_o === v && n < 20) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n < 20) lat = n;
  end
  // ==========================================================
  // tests
  initial begin
    tick(6);
    reset_n_i <= 1'b1;
    tick(4);
    addr({7'h2c, 1'b0});
    chk("addr", r, {7'h2c, 2'b00});
    held(8'h21);
    put(1, 8'h00);
    chk("release", {8'h00, scl_oe_o}, 9'h000);
    mst.xfer(8'ha5, 1'b1, r);
    chk("rx ack", r, {8'ha5, 1'b0});
    held(8'h22);
    chk("rx data", {1'b0, data_reg_o}, 9'h0a5);
    put(1, 8'h00);
    mst.stop();
    stat(8'h04);
    put(1, 8'hff);
    stat(8'h00);
    for (int h = 1; h >= 0; h--) begin
      sda_hold_count_i <= 8'(h);
      addr({7'h51, 1'b1});
      chk("addr2", r, {7'h51, 2'b10});
      held(8'h31);
      put(0, 8'h55);
      put(1, 8'h00);
      meas = 1;
      mst.xfer(8'hff, 1'b0, r);
      meas = 0;
      chk("tx", r, {8'h55, 1'b0});
      chk("hold", {8'h00, (lat >= h + 2 && lat <= h + 5)}, 9'h001);
      held(8'h32);
      put(0, 8'hc3);
      put(1, 8'h00);
      mst.xfer(8'hff, 1'b1, r);
      chk("tx next", r, {8'hc3, 1'b1});
      held(8'h32);
      put(1, 8'h00);
      mst.xfer(8'hff, 1'b1, r);
      chk("after nack", r, 9'h1ff);
      mst.stop();
      put(1, 8'hff);
    end
    addr({7'h33, 1'b0});
    chk("foreign", r, {7'h33, 2'b01});
    stat(8'h00);
    general_call_enable2_i <= 1'b1;
    addr(8'h00);
    chk("gcall", r, 9'h000);
    held(8'h21);
    put(1, 8'h00);
    for (int i = 0; i < 3; i++) mst.bitx(1'b1, r[0]);
    addr({7'h2c, 1'b0});
    chk("restart", r, {7'h2c, 2'b00});
    held(8'h21);
    put(1, 8'hff);
    mst.stop();
    tick(1);
    ack_enable_i <= 1'b0;
    addr({7'h2c, 1'b0});
    chk("no ack", r, {7'h2c, 2'b01});
    stat(8'h00);
    ack_enable_i <= 1'b1;
    addr({7'h2c, 1'b0});
    held(8'h21);
    ack_enable_i <= 1'b0;
    put(1, 8'h00);
    mst.xfer(8'h3c, 1'b1, r);
    chk("withheld", r, {8'h3c, 1'b1});
    held(8'h22);
    put(1, 8'h00);
    mst.stop();
    stat(8'h04);
    put(1, 8'hff);
    controller_enable_bit_i <= 1'b0;
    ack_enable_i <= 1'b1;
    addr({7'h2c, 1'b0});
    chk("disabled", r, {7'h2c, 2'b01});
    stat(8'h00);
    mst.stop();
    tally_and_finish();
  end
endmodule // isl_slave_top_bench
bind isl_slave_top isl_slave_props #(.HOLD_W(HOLD_W)) props_i (.*);
